// File: rtl/freq_locked_loop_pkg.sv
package freq_locked_loop_pkg;

	localparam int ADDR_W      = 11;
	localparam int DATA_W      = 16;
	localparam int NUM_REF     = 10;
	localparam int INTEG_W     = 24;

	// Register indices; byte address is four times the index
	localparam logic [8:0] IDX_REF_ENA_CTRL  = 9'h171;
	localparam logic [8:0] IDX_INT_MULT      = 9'h172;
	localparam logic [8:0] IDX_FRAC_NUM      = 9'h173;
	localparam logic [8:0] IDX_FRAC_DEN      = 9'h174;
	localparam logic [8:0] IDX_FB_RATIO      = 9'h175;
	localparam logic [8:0] IDX_REF_DET_DIV   = 9'h176;
	localparam logic [8:0] IDX_TREE_SEL      = 9'h17e;
	localparam logic [8:0] IDX_STATUS        = 9'h17f;

	localparam int ENA_BIT      = 0;
	localparam int HOLD_BIT     = 2;
	localparam int APPLY_BIT    = 15;
	localparam int REFDET_BIT   = 15;
	localparam int DIV_LSB      = 6;
	localparam int SRC_LSB      = 0;

	localparam logic        ENA_RST    = 1'b0;
	localparam logic        HOLD_RST   = 1'b1;
	localparam logic        REFDET_RST = 1'b1;
	localparam logic [9:0]  N_RST      = 10'h004;
	localparam logic [15:0] NUM_RST    = 16'h0000;
	localparam logic [15:0] DEN_RST    = 16'h0000;
	localparam logic [9:0]  FB_RST     = 10'h001;
	localparam logic [1:0]  DIV_RST    = 2'h0;
	localparam logic [3:0]  SRC_RST    = 4'h0;
	localparam logic [INTEG_W-1:0] INTEG_RST = 24'h800000;

	localparam logic [3:0] SRC_MASTER_ONE   = 4'h0;
	localparam logic [3:0] SRC_MASTER_TWO   = 4'h1;
	localparam logic [3:0] SRC_MASTER_THREE = 4'h2;
	localparam logic [3:0] SRC_SERIAL_LINK  = 4'h3;
	localparam logic [3:0] SRC_BIT_ONE      = 4'h8;
	localparam logic [3:0] SRC_BIT_TWO      = 4'h9;
	localparam logic [3:0] SRC_BIT_THREE    = 4'ha;
	localparam logic [3:0] SRC_FRAME_ONE    = 4'hc;
	localparam logic [3:0] SRC_FRAME_TWO    = 4'hd;
	localparam logic [3:0] SRC_FRAME_THREE  = 4'he;

	localparam int CLK_PERIOD_NS      = 10;
	localparam int REF_TIMEOUT_NS     = 100000;
	localparam int REF_TIMEOUT_CYCLES = (REF_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic [3:0]  src;
		logic [1:0]  div;
		logic [9:0]  n;
		logic [15:0] num;
		logic [15:0] den;
		logic [9:0]  fb;
	} loop_cfg_s;

	typedef struct packed {
		logic core_audio;
		logic secondary_audio;
		logic processor;
	} tree_sel_s;

	typedef enum logic [3:0] {
		ST_OFF   = 4'b0001,
		ST_TRACK = 4'b0010,
		ST_HOLD  = 4'b0100,
		ST_FREE  = 4'b1000
	} loop_state_e;

	// Selected reference level; reserved codes give a dead input
	function automatic logic ref_level(input logic [3:0] src, input logic [NUM_REF-1:0] pins);
		logic lvl;
		lvl = 1'b0;
		case (src)
			SRC_MASTER_ONE:   lvl = pins[0];
			SRC_MASTER_TWO:   lvl = pins[1];
			SRC_MASTER_THREE: lvl = pins[2];
			SRC_SERIAL_LINK:  lvl = pins[3];
			SRC_BIT_ONE:      lvl = pins[4];
			SRC_BIT_TWO:      lvl = pins[5];
			SRC_BIT_THREE:    lvl = pins[6];
			SRC_FRAME_ONE:    lvl = pins[7];
			SRC_FRAME_TWO:    lvl = pins[8];
			SRC_FRAME_THREE:  lvl = pins[9];
			default:          lvl = 1'b0;
		endcase
		return lvl;
	endfunction

endpackage

// File: rtl/ref_predivide_detect.sv
module ref_predivide_detect
	import freq_locked_loop_pkg::*;
#(
	parameter int TIMEOUT = REF_TIMEOUT_CYCLES
) (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst,
	input  wire logic       i_ref_level,
	input  wire logic [1:0] i_div,
	input  wire logic       i_det_en,
	output logic            o_ref_edge,
	output logic            o_ref_present
);

	logic        prev_level;
	logic [2:0]  div_cnt;
	logic [31:0] idle_cnt;
	logic [2:0]  div_mask;
	logic        rise;

	assign rise = i_ref_level & ~prev_level;

	always_comb begin
		case (i_div)
			2'h0:    div_mask = 3'h0;
			2'h1:    div_mask = 3'h1;
			2'h2:    div_mask = 3'h3;
			default: div_mask = 3'h7;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			prev_level <= 1'b0;
		end else begin
			prev_level <= i_ref_level;
		end
	end

	// One divided edge every 1, 2, 4 or 8 reference edges
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			div_cnt    <= 3'h0;
			o_ref_edge <= 1'b0;
		end else begin
			o_ref_edge <= 1'b0;
			if (rise) begin
				if ((div_cnt & div_mask) == div_mask) begin
					div_cnt    <= 3'h0;
					o_ref_edge <= 1'b1;
				end else begin
					div_cnt <= div_cnt + 3'h1;
				end
			end
		end
	end

	// Stopped reference: no raw edge for the timeout span
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			idle_cnt      <= 32'h0;
			o_ref_present <= 1'b0;
		end else begin
			if (rise) begin
				idle_cnt <= 32'h0;
			end else if (idle_cnt < TIMEOUT) begin
				idle_cnt <= idle_cnt + 32'h1;
			end
			o_ref_present <= ~i_det_en | rise | (idle_cnt < TIMEOUT - 1);
		end
	end

endmodule

// File: rtl/freq_locked_loop_config_hold.sv
module freq_locked_loop_config_hold
	import freq_locked_loop_pkg::*;
#(
	parameter int REF_TIMEOUT = REF_TIMEOUT_CYCLES,
	parameter int MEAS_W      = 20
) (
	input  wire logic                i_core_clk,
	input  wire logic                i_rst,
	input  wire logic [ADDR_W-1:0]   i_addr,
	input  wire logic [DATA_W-1:0]   i_wdata,
	input  wire logic                i_wr,
	input  wire logic                i_rd,
	output logic      [DATA_W-1:0]   o_rdata,
	input  wire logic [NUM_REF-1:0]  i_ref_pins,
	input  wire logic                i_osc_tick,
	output logic      [INTEG_W-1:0]  o_osc_word,
	output tree_sel_s                o_tree_sel,
	output logic                     o_loop_run,
	output logic                     o_free_running
);

	// Software-visible state
	logic        loop_enable;
	logic        holdover_select;
	logic        reference_detect_enable;
	loop_cfg_s   pend_cfg;
	loop_cfg_s   next_pend_cfg;
	loop_cfg_s   act_cfg;
	tree_sel_s   tree_sel;

	// Bus decode
	logic [8:0]  idx;
	logic        aligned;
	logic        wr_ctrl;
	logic        wr_mult;
	logic        wr_num;
	logic        wr_den;
	logic        wr_fb;
	logic        wr_det;
	logic        wr_tree;
	logic        apply;

	// Synchronisers and loop
	logic [NUM_REF-1:0] ref_meta;
	logic [NUM_REF-1:0] ref_sync;
	logic [2:0]         osc_sync;
	logic               osc_edge;
	logic               ref_edge;
	logic               ref_present;
	loop_state_e        state;
	loop_state_e        next_state;
	logic               primed;
	logic [MEAS_W-1:0]  meas_cnt;
	logic [INTEG_W-1:0] integ;
	logic [15:0]        den_eff;
	logic [15:0]        num_eff;
	logic [37:0]        meas_scaled;
	logic [37:0]        target_scaled;

	assign idx     = i_addr[ADDR_W-1:2];
	assign aligned = (i_addr[1:0] == 2'h0);
	assign wr_ctrl = i_wr & aligned & (idx == IDX_REF_ENA_CTRL);
	assign wr_mult = i_wr & aligned & (idx == IDX_INT_MULT);
	assign wr_num  = i_wr & aligned & (idx == IDX_FRAC_NUM);
	assign wr_den  = i_wr & aligned & (idx == IDX_FRAC_DEN);
	assign wr_fb   = i_wr & aligned & (idx == IDX_FB_RATIO);
	assign wr_det  = i_wr & aligned & (idx == IDX_REF_DET_DIV);
	assign wr_tree = i_wr & aligned & (idx == IDX_TREE_SEL);
	assign apply   = wr_mult & i_wdata[APPLY_BIT] & loop_enable;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			loop_enable     <= ENA_RST;
			holdover_select <= HOLD_RST;
		end else if (wr_ctrl) begin
			loop_enable     <= i_wdata[ENA_BIT];
			holdover_select <= i_wdata[HOLD_BIT];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			reference_detect_enable <= REFDET_RST;
		end else if (wr_det) begin
			reference_detect_enable <= i_wdata[REFDET_BIT];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			tree_sel <= '0;
		end else if (wr_tree) begin
			tree_sel <= tree_sel_s'(i_wdata[2:0]);
		end
	end

	// Pending field values as they will look after this cycle's write
	always_comb begin
		next_pend_cfg = pend_cfg;
		if (wr_mult) begin
			next_pend_cfg.n = i_wdata[9:0];
		end
		if (wr_num) begin
			next_pend_cfg.num = i_wdata;
		end
		if (wr_den) begin
			next_pend_cfg.den = i_wdata;
		end
		if (wr_fb) begin
			next_pend_cfg.fb = i_wdata[9:0];
		end
		if (wr_det) begin
			next_pend_cfg.div = i_wdata[DIV_LSB+1:DIV_LSB];
			next_pend_cfg.src = i_wdata[SRC_LSB+3:SRC_LSB];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			pend_cfg.src <= SRC_RST;
			pend_cfg.div <= DIV_RST;
			pend_cfg.n   <= N_RST;
			pend_cfg.num <= NUM_RST;
			pend_cfg.den <= DEN_RST;
			pend_cfg.fb  <= FB_RST;
		end else begin
			pend_cfg <= next_pend_cfg;
		end
	end

	// Values the loop really uses: follow writes while disabled, else only on apply
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			act_cfg.src <= SRC_RST;
			act_cfg.div <= DIV_RST;
			act_cfg.n   <= N_RST;
			act_cfg.num <= NUM_RST;
			act_cfg.den <= DEN_RST;
			act_cfg.fb  <= FB_RST;
		end else if (!loop_enable) begin
			act_cfg <= next_pend_cfg;
		end else if (apply) begin
			act_cfg <= next_pend_cfg;
		end
	end

	// Read data stand one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_rdata <= 16'h0000;
		end else if (i_rd && aligned) begin
			case (idx)
				IDX_REF_ENA_CTRL: begin
					o_rdata <= 16'h0000;
					o_rdata[ENA_BIT]  <= loop_enable;
					o_rdata[HOLD_BIT] <= holdover_select;
				end
				IDX_INT_MULT: begin
					o_rdata <= {6'h00, pend_cfg.n};
				end
				IDX_FRAC_NUM: begin
					o_rdata <= pend_cfg.num;
				end
				IDX_FRAC_DEN: begin
					o_rdata <= pend_cfg.den;
				end
				IDX_FB_RATIO: begin
					o_rdata <= {6'h00, pend_cfg.fb};
				end
				IDX_REF_DET_DIV: begin
					o_rdata <= {reference_detect_enable, 7'h00, pend_cfg.div, 2'h0, pend_cfg.src};
				end
				IDX_TREE_SEL: begin
					o_rdata <= {13'h0000, tree_sel};
				end
				IDX_STATUS: begin
					o_rdata <= {9'h000, primed, ref_present, 1'b0, state};
				end
				default: begin
					o_rdata <= 16'h0000;
				end
			endcase
		end else begin
			o_rdata <= 16'h0000;
		end
	end

	// Reference and oscillator inputs cross in through two flops
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			ref_meta <= '0;
			ref_sync <= '0;
			osc_sync <= 3'h0;
		end else begin
			ref_meta <= i_ref_pins;
			ref_sync <= ref_meta;
			osc_sync <= {osc_sync[1:0], i_osc_tick};
		end
	end

	assign osc_edge = osc_sync[1] & ~osc_sync[2];

	ref_predivide_detect #(
		.TIMEOUT (REF_TIMEOUT)
	) u_ref_detect (
		.i_core_clk    (i_core_clk),
		.i_rst         (i_rst),
		.i_ref_level   (ref_level(act_cfg.src, ref_sync)),
		.i_div         (act_cfg.div),
		.i_det_en      (reference_detect_enable),
		.o_ref_edge    (ref_edge),
		.o_ref_present (ref_present)
	);

	always_comb begin
		if (!loop_enable) begin
			next_state = ST_OFF;
		end else if (!ref_present) begin
			next_state = ST_FREE;
		end else if (holdover_select) begin
			next_state = ST_HOLD;
		end else begin
			next_state = ST_TRACK;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// First reference edge after entering tracking only starts a measurement
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			primed <= 1'b0;
		end else if (state != ST_TRACK) begin
			primed <= 1'b0;
		end else if (ref_edge) begin
			primed <= 1'b1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			meas_cnt <= '0;
		end else if (state != ST_TRACK || ref_edge) begin
			meas_cnt <= osc_edge ? MEAS_W'(1) : '0;
		end else if (osc_edge && meas_cnt != '1) begin
			meas_cnt <= meas_cnt + MEAS_W'(1);
		end
	end

	// Compare in denominator units: count*den against fb*(n*den + num)
	assign den_eff       = (act_cfg.den == 16'h0000) ? 16'h0001 : act_cfg.den;
	assign num_eff       = (act_cfg.den == 16'h0000) ? 16'h0000 : act_cfg.num;
	assign meas_scaled   = 38'(meas_cnt) * 38'(den_eff);
	assign target_scaled = 38'(act_cfg.fb) * (38'(act_cfg.n) * 38'(den_eff) + 38'(num_eff));

	// Integrator moves only while tracking; held in holdover and free-run
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			integ <= INTEG_RST;
		end else begin
			case (state)
				ST_TRACK: begin
					if (ref_edge && primed) begin
						if (meas_scaled < target_scaled && integ != '1) begin
							integ <= integ + INTEG_W'(1);
						end else if (meas_scaled > target_scaled && integ != '0) begin
							integ <= integ - INTEG_W'(1);
						end
					end
				end
				ST_HOLD: begin
					integ <= integ;
				end
				ST_FREE: begin
					integ <= integ;
				end
				ST_OFF: begin
					integ <= integ;
				end
				default: begin
					integ <= integ;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_osc_word     <= INTEG_RST;
			o_loop_run     <= 1'b0;
			o_free_running <= 1'b0;
			o_tree_sel     <= '0;
		end else begin
			o_osc_word     <= integ;
			o_loop_run     <= loop_enable;
			o_free_running <= (next_state == ST_FREE) | (next_state == ST_HOLD);
			o_tree_sel     <= loop_enable ? tree_sel : '0;
		end
	end

endmodule

// File: dv/freq_locked_loop_config_hold_checker.sv
module freq_locked_loop_config_hold_checker
	import freq_locked_loop_pkg::*;
#(
	parameter int REF_TIMEOUT = REF_TIMEOUT_CYCLES,
	parameter int MEAS_W      = 20
) (
	input wire logic                i_core_clk,
	input wire logic                i_rst,
	input wire logic [ADDR_W-1:0]   i_addr,
	input wire logic [DATA_W-1:0]   i_wdata,
	input wire logic                i_wr,
	input wire logic                i_rd,
	input wire logic [DATA_W-1:0]   o_rdata,
	input wire logic [NUM_REF-1:0]  i_ref_pins,
	input wire logic                i_osc_tick,
	input wire logic [INTEG_W-1:0]  o_osc_word,
	input wire tree_sel_s           o_tree_sel,
	input wire logic                o_loop_run,
	input wire logic                o_free_running
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == '0)
		else $error("read data outside its slot");
	tree_off_a: assert property (!o_loop_run |-> o_tree_sel == '0)
		else $error("tree select live while loop off");
	hold_freeze_a: assert property (o_free_running && $past(o_free_running) && $past(o_free_running, 2)
		|-> $stable(o_osc_word))
		else $error("integrator moved while free running");
	word_step_a: assert property ($changed(o_osc_word) |->
		(o_osc_word - $past(o_osc_word) == 24'h1) || ($past(o_osc_word) - o_osc_word == 24'h1))
		else $error("integrator step not one");
	free_enabled_a: assert property (o_free_running |-> o_loop_run)
		else $error("free running while disabled");
	apply_reads_a: assert property ($past(i_rd) && $past(i_addr) == 11'h5c8 |-> o_rdata[15:10] == 6'h0)
		else $error("apply strobe reads back");
	status_hot_a: assert property ($past(i_rd) && $past(i_addr) == 11'h5fc |-> $onehot(o_rdata[3:0]))
		else $error("loop state not one-hot");
	status_off_a: assert property ($past(i_rd) && $past(i_addr) == 11'h5fc && !$past(o_loop_run)
		&& !$past(o_loop_run, 2) |-> o_rdata[3:0] == 4'h1)
		else $error("disabled loop not off");
	reset_quiet_a: assert property ($past(i_rst) |-> !o_loop_run && !o_free_running && o_osc_word == 24'h800000)
		else $error("outputs wrong after reset");

	cover property (o_free_running && o_loop_run);
	cover property (o_loop_run && $changed(o_osc_word));
	cover property (o_tree_sel == 3'b111);
endmodule

bind freq_locked_loop_config_hold freq_locked_loop_config_hold_checker #(.REF_TIMEOUT(REF_TIMEOUT), .MEAS_W(MEAS_W)) chk (
	.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_ref_pins(i_ref_pins), .i_osc_tick(i_osc_tick), .o_osc_word(o_osc_word),
	.o_tree_sel(o_tree_sel), .o_loop_run(o_loop_run), .o_free_running(o_free_running));

// File: dv/freq_locked_loop_config_hold_test.sv
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module freq_locked_loop_config_hold_test
	import freq_locked_loop_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic               i_core_clk = 1'b0;
	logic               i_rst      = 1'b1;
	logic [ADDR_W-1:0]  i_addr     = '0;
	logic [DATA_W-1:0]  i_wdata    = '0;
	logic               i_wr       = 1'b0;
	logic               i_rd       = 1'b0;
	logic [NUM_REF-1:0] i_ref_pins = '0;
	logic               i_osc_tick = 1'b0;
	logic [DATA_W-1:0]  o_rdata;
	logic [INTEG_W-1:0] o_osc_word;
	tree_sel_s          o_tree_sel;
	logic               o_loop_run;
	logic               o_free_running;
	logic               ref_on     = 1'b0;
	logic               osc_on     = 1'b0;
	logic [2:0]         rcnt       = '0;
	logic [DATA_W-1:0]  d;
	logic [INTEG_W-1:0] w;
	int                 miscompares = 0;
	int                 checked     = 0;
	localparam logic [10:0] RA [6] = '{11'h5c4, 11'h5c8, 11'h5cc, 11'h5d0, 11'h5d4, 11'h5d8};
	localparam logic [15:0] RV [6] = '{16'h0004, 16'h0004, 16'h0000, 16'h0000, 16'h0001, 16'h8000};

	freq_locked_loop_config_hold #(.REF_TIMEOUT(50)) DUT (
		.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_ref_pins(i_ref_pins), .i_osc_tick(i_osc_tick), .o_osc_word(o_osc_word),
		.o_tree_sel(o_tree_sel), .o_loop_run(o_loop_run), .o_free_running(o_free_running));

	always #5 i_core_clk = ~i_core_clk;

	// All references toggle together, one raw rising edge per 16 cycles
	always @(posedge i_core_clk) begin
		rcnt <= rcnt + 3'h1;
		if (ref_on && rcnt == 3'h0) begin
			i_ref_pins <= ~i_ref_pins;
		end
	end

	// Oscillator feedback, one rising edge per 2 cycles while on
	always @(posedge i_core_clk) begin
		if (osc_on) begin
			i_osc_tick <= ~i_osc_tick;
		end
	end

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask

	task automatic state_is(input logic [3:0] s);
		rd(11'h5fc, d);
		`CHK(d[3:0], s)
	endtask

	task automatic done_t(input string n);
		$display("test %s ended", n);
	endtask

	task automatic close_out();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge i_core_clk);
		miscompares++;
		close_out();
	end

	initial begin
		repeat (3) @(posedge i_core_clk);
		i_rst <= 1'b0;
		for (int k = 0; k < 6; k++) begin
			rd(RA[k], d);
			`CHK(d, RV[k])
		end
		rd(11'h5e0, d);
		`CHK(d, 16'h0000)
		rd(11'h5c6, d);
		`CHK(d, 16'h0000)
		done_t("reset");
		wr(11'h5c8, 16'h0000);
		ref_on <= 1'b1;
		wr(11'h5c4, 16'h0001);
		wait_n(100);
		`CHK(o_osc_word, 24'h800000)
		state_is(4'h2);
		wr(11'h5c8, 16'h0004);
		wait_n(100);
		`CHK(o_osc_word, 24'h800000)
		wr(11'h5c4, 16'h0005);
		wr(11'h5c8, 16'h8004);
		wait_n(2);
		w = o_osc_word;
		wait_n(100);
		`CHK(o_osc_word, w)
		`CHK(o_free_running, 1'b1)
		state_is(4'h4);
		wr(11'h5c4, 16'h0001);
		wait_n(100);
		`CHK(o_osc_word > 24'h800000, 1'b1)
		done_t("apply");
		ref_on <= 1'b0;
		wait_n(120);
		state_is(4'h8);
		w = o_osc_word;
		wait_n(50);
		`CHK(o_osc_word, w)
		ref_on <= 1'b1;
		wait_n(100);
		state_is(4'h2);
		`CHK(o_free_running, 1'b0)
		done_t("holdover");
		wr(11'h5c4, 16'h0005);
		wr(11'h5cc, 16'h0001);
		wr(11'h5d0, 16'h0003);
		wr(11'h5c8, 16'h8000);
		wr(11'h5c4, 16'h0001);
		rd(11'h5cc, d);
		`CHK(d, 16'h0001)
		rd(11'h5d0, d);
		`CHK(d, 16'h0003)
		w = o_osc_word;
		wait_n(100);
		`CHK(o_osc_word > w, 1'b1)
		osc_on <= 1'b1;
		wait_n(4);
		w = o_osc_word;
		wait_n(100);
		`CHK(o_osc_word < w, 1'b1)
		osc_on <= 1'b0;
		done_t("fraction");
		wr(11'h5f8, 16'h0007);
		wait_n(2);
		`CHK(o_tree_sel, 3'b111)
		// Reserved codes select a dead input
		for (int c = 0; c < 16; c++) begin
			wr(11'h5c4, 16'h0005);
			wr(11'h5d8, 16'h8000 | 16'(c));
			wr(11'h5c8, 16'h8004);
			wr(11'h5c4, 16'h0001);
			wait_n(120);
			state_is((c < 4 || (c >= 8 && c != 11 && c != 15)) ? 4'h2 : 4'h8);
		end
		wr(11'h5d8, 16'h00c4);
		wait_n(5);
		state_is(4'h2);
		rd(11'h5d8, d);
		`CHK(d, 16'h00c4)
		wr(11'h5c4, 16'h0000);
		wait_n(3);
		`CHK(o_tree_sel, 3'b000)
		`CHK(o_loop_run, 1'b0)
		state_is(4'h1);
		done_t("sources");
		close_out();
	end
endmodule
